// *** mdsi_pkg.sv ***
// Package: register map, field positions and reset values for the DMA status block
package mdsi_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_TXQ_PTR = 8'h1c;
  localparam logic [7:0] OFF_RX_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN_SET = 8'h28;
  localparam logic [7:0] OFF_IRQ_EN_CLR = 8'h2c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_TX_STATUS = 8'h14;
  // Receive status bits
  localparam int unsigned RS_BUF_UNAVAIL = 0;
  localparam int unsigned RS_FRAME_RCVD = 1;
  localparam int unsigned RS_OVERRUN = 2;
  localparam int unsigned RS_W = 3;
  // Transmit status active bit
  localparam int unsigned TS_ACTIVE = 3;
  // Interrupt bit positions
  localparam int unsigned IB_MGMT_DONE = 0;
  localparam int unsigned IB_RX_COMPLETE = 1;
  localparam int unsigned IB_RX_USED = 2;
  localparam int unsigned IB_TX_USED = 3;
  localparam int unsigned IB_TX_UNDERRUN = 4;
  localparam int unsigned IB_RETRY_LIMIT = 5;
  localparam int unsigned IB_TX_EXHAUST = 6;
  localparam int unsigned IB_TX_COMPLETE = 7;
  localparam int unsigned IB_RX_OVERRUN = 10;
  localparam int unsigned IB_BUS_ERROR = 11;
  localparam int unsigned IB_PAUSE_FRAME = 12;
  localparam int unsigned IB_PAUSE_ZERO = 13;
  localparam int unsigned IRQ_W = 14;
  localparam logic [13:0] IRQ_IMPL = 14'h3cff;
  // Masked after reset: all sources disabled
  localparam logic [13:0] MASK_RST = 14'h3fff;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam int unsigned PTR_STEP = 8;
  localparam int unsigned WRAP_BUFS = 1024;
  localparam int unsigned PTR_LOW_W = 13;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : mdsi_pkg

// *** mdsi_top.sv ***
// Module: MAC DMA queue pointer, receive status and interrupt registers
`timescale 1ns/1ps
module mdsi_top
  import mdsi_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [mdsi_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_TX_ACTIVE,
  input wire logic I_TX_BUF_DONE,
  input wire logic I_TX_WRAP_SEEN,
  input wire logic I_TX_FRAME_DONE,
  input wire logic I_RX_DESC_OWNED,
  input wire logic I_RX_FRAME_STORED,
  input wire logic I_RX_STORE_FAIL,
  input wire logic I_RX_USED_SEEN,
  input wire logic I_TX_USED_SEEN,
  input wire logic I_TX_LATE_DATA,
  input wire logic I_TX_USED_MIDFRAME,
  input wire logic I_BUS_ERROR,
  input wire logic I_MGMT_DONE,
  input wire logic I_RETRY_LIMIT,
  input wire logic I_TX_EXHAUST,
  input wire logic I_PAUSE_FRAME,
  input wire logic I_PAUSE_ZERO,
  output logic [31:0] O_TXQ_PTR,
  output logic O_PTR_LOAD,
  output logic O_IRQ
);
  import mdsi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  assign acc = I_PSEL & I_PENABLE;
  assign wr = acc & I_PWRITE;
  assign rd = acc & ~I_PWRITE;
  assign hit = (I_PADDR == OFF_TXQ_PTR) || (I_PADDR == OFF_RX_STATUS) ||
               (I_PADDR == OFF_IRQ_STATUS) || (I_PADDR == OFF_IRQ_EN_SET) ||
               (I_PADDR == OFF_IRQ_EN_CLR) || (I_PADDR == OFF_IRQ_MASK) ||
               (I_PADDR == OFF_TX_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue pointer
  logic [31:0] ptr_base_r, ptr_base_nxt;
  logic [31:0] ptr_cur_r, ptr_cur_nxt;
  logic [31:0] ptr_frame_r, ptr_frame_nxt;
  logic [10:0] buf_cnt_r, buf_cnt_nxt;
  logic ptr_load_r, ptr_load_nxt;
  logic ptr_wr;

  assign ptr_wr = wr && (I_PADDR == OFF_TXQ_PTR) && !I_TX_ACTIVE;

  always_comb begin
    ptr_base_nxt = ptr_base_r;
    ptr_cur_nxt = ptr_cur_r;
    ptr_frame_nxt = ptr_frame_r;
    buf_cnt_nxt = buf_cnt_r;
    ptr_load_nxt = 1'b0;
    if (ptr_wr) begin
      ptr_base_nxt = I_PWDATA;
      ptr_cur_nxt = I_PWDATA;
      ptr_frame_nxt = I_PWDATA;
      buf_cnt_nxt = '0;
      ptr_load_nxt = 1'b1;
    end else begin
      if (I_TX_BUF_DONE) begin
        // Wrap reloads the whole base pointer; on advance the high bits never move
        if (I_TX_WRAP_SEEN ||
            buf_cnt_r == 11'(WRAP_BUFS - 1)) begin
          ptr_cur_nxt = ptr_base_r;
          buf_cnt_nxt = '0;
        end else begin
          ptr_cur_nxt = {ptr_base_r[31:PTR_LOW_W],
                         ptr_cur_r[PTR_LOW_W-1:0] +
                         PTR_LOW_W'(PTR_STEP)};
          buf_cnt_nxt = buf_cnt_r + 11'h001;
        end
      end
      if (I_TX_FRAME_DONE) begin
        ptr_frame_nxt = I_TX_BUF_DONE ? ptr_cur_nxt : ptr_cur_r;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      ptr_base_r <= PTR_RST;
      ptr_cur_r <= PTR_RST;
      ptr_frame_r <= PTR_RST;
      buf_cnt_r <= '0;
      ptr_load_r <= 1'b0;
    end else begin
      ptr_base_r <= ptr_base_nxt;
      ptr_cur_r <= ptr_cur_nxt;
      ptr_frame_r <= ptr_frame_nxt;
      buf_cnt_r <= buf_cnt_nxt;
      ptr_load_r <= ptr_load_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive status flags, write-one-to-clear, set wins
  logic [RS_W-1:0] rx_stat_r, rx_stat_nxt;
  logic [RS_W-1:0] rx_set;
  logic [RS_W-1:0] rx_clr;

  always_comb begin
    rx_set = '0;
    rx_set[RS_BUF_UNAVAIL] = I_RX_DESC_OWNED;
    rx_set[RS_FRAME_RCVD] = I_RX_FRAME_STORED;
    rx_set[RS_OVERRUN] = I_RX_STORE_FAIL;
    rx_clr = (wr && I_PADDR == OFF_RX_STATUS) ? I_PWDATA[RS_W-1:0] : '0;
    rx_stat_nxt = (rx_stat_r & ~rx_clr) | rx_set;
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_stat_r <= '0;
    end else begin
      rx_stat_r <= rx_stat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt;
  logic [IRQ_W-1:0] irq_set;
  logic irq_rd;
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  assign irq_rd = rd && (I_PADDR == OFF_IRQ_STATUS);

  always_comb begin
    irq_set = '0;
    irq_set[IB_MGMT_DONE] = I_MGMT_DONE;
    irq_set[IB_RX_COMPLETE] = I_RX_FRAME_STORED;
    irq_set[IB_RX_USED] = I_RX_USED_SEEN;
    irq_set[IB_TX_USED] = I_TX_USED_SEEN;
    irq_set[IB_TX_UNDERRUN] = I_TX_LATE_DATA | I_BUS_ERROR |
                              I_TX_USED_MIDFRAME | ptr_wr;
    irq_set[IB_RETRY_LIMIT] = I_RETRY_LIMIT;
    irq_set[IB_TX_EXHAUST] = I_TX_EXHAUST;
    irq_set[IB_TX_COMPLETE] = I_TX_FRAME_DONE;
    irq_set[IB_RX_OVERRUN] = I_RX_STORE_FAIL;
    irq_set[IB_BUS_ERROR] = I_BUS_ERROR;
    irq_set[IB_PAUSE_FRAME] = I_PAUSE_FRAME;
    irq_set[IB_PAUSE_ZERO] = I_PAUSE_ZERO;
    // Only flags shown by the read are cleared; later ones stay pending
    irq_stat_nxt = (irq_rd ? (irq_stat_r & ~rdata_r[IRQ_W-1:0]) : irq_stat_r)
                   | irq_set;
    mask_nxt = mask_r;
    if (wr && I_PADDR == OFF_IRQ_EN_SET) begin
      mask_nxt = mask_r & ~(I_PWDATA[IRQ_W-1:0] & IRQ_IMPL);
    end
    if (wr && I_PADDR == OFF_IRQ_EN_CLR) begin
      mask_nxt = mask_r | (I_PWDATA[IRQ_W-1:0] & IRQ_IMPL);
    end
    irq_nxt = |(irq_stat_nxt & ~mask_nxt);
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_stat_r <= '0;
      mask_r <= MASK_RST;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; answers in the access cycle, data registered in setup
  logic slverr_r, slverr_nxt;
  logic pready_r, pready_nxt;
  logic setup;
  assign setup = I_PSEL & ~I_PENABLE;

  always_comb begin
    rdata_nxt = rdata_r;
    slverr_nxt = 1'b0;
    pready_nxt = setup;
    if (setup) begin
      rdata_nxt = ZERO32;
      slverr_nxt = !hit;
      case (I_PADDR)
        OFF_TXQ_PTR: rdata_nxt = ptr_frame_r;
        OFF_RX_STATUS: rdata_nxt = {{(32-RS_W){1'b0}}, rx_stat_r};
        OFF_IRQ_STATUS: rdata_nxt = {{(32-IRQ_W){1'b0}}, irq_stat_r};
        OFF_IRQ_MASK: rdata_nxt = {{(32-IRQ_W){1'b0}}, mask_r};
        OFF_TX_STATUS: rdata_nxt[TS_ACTIVE] = I_TX_ACTIVE;
        default: rdata_nxt = ZERO32;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_r <= ZERO32;
      slverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      slverr_r <= slverr_nxt;
      pready_r <= pready_nxt;
    end
  end

  // Status read in the access phase returns the value seen at setup,
  // so events arriving in the setup cycle itself stay pending.
  always_comb begin
    O_PRDATA = rdata_r;
    O_PSLVERR = slverr_r;
    O_PREADY = pready_r;
    O_TXQ_PTR = ptr_cur_r;
    O_PTR_LOAD = ptr_load_r;
    O_IRQ = irq_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_ptr_write_blocked: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (wr && I_PADDR == OFF_TXQ_PTR && I_TX_ACTIVE) |=>
      ptr_base_r == $past(ptr_base_r))
    else $error("pointer written while transmit active");
  a_ptr_write_load: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    ptr_wr |=> ptr_cur_r == $past(I_PWDATA) && O_PTR_LOAD)
    else $error("pointer write not loaded");
  a_ptr_wrap_base: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (!ptr_wr && I_TX_BUF_DONE && I_TX_WRAP_SEEN) |=>
      ptr_cur_r == ptr_base_r)
    else $error("pointer did not wrap");
  a_ptr_advance: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (!ptr_wr && I_TX_BUF_DONE && !I_TX_WRAP_SEEN &&
     buf_cnt_r != 11'(WRAP_BUFS - 1)) |=>
      ptr_cur_r[PTR_LOW_W-1:0] ==
        $past(ptr_cur_r[PTR_LOW_W-1:0]) + PTR_LOW_W'(PTR_STEP))
    else $error("pointer did not advance by one step");
  a_ptr_readback: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (setup && I_PADDR == OFF_TXQ_PTR) |=> O_PRDATA == $past(ptr_frame_r))
    else $error("pointer read does not show frame start");
  a_rx_w1c_clear: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (wr && I_PADDR == OFF_RX_STATUS && I_PWDATA[RS_OVERRUN] &&
     !I_RX_STORE_FAIL) |=> !rx_stat_r[RS_OVERRUN])
    else $error("overrun flag not cleared");
  a_rx_write_no_set: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (wr && I_PADDR == OFF_RX_STATUS && !rx_stat_r[RS_OVERRUN] &&
     !I_RX_STORE_FAIL) |=> !rx_stat_r[RS_OVERRUN])
    else $error("written one set a receive flag");
  a_rx_set_wins: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_RX_DESC_OWNED |=> rx_stat_r[RS_BUF_UNAVAIL])
    else $error("buffer unavailable flag lost");
  a_rx_nowrite_set: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (!rx_stat_r[RS_FRAME_RCVD] && !I_RX_FRAME_STORED) |=>
      !rx_stat_r[RS_FRAME_RCVD])
    else $error("frame received set without cause");
  a_rx_complete: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_RX_FRAME_STORED |=>
      irq_stat_r[IB_RX_COMPLETE] && rx_stat_r[RS_FRAME_RCVD])
    else $error("stored frame not flagged");
  a_irq_read_clear: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (irq_rd && O_PRDATA[IB_PAUSE_FRAME] && !I_PAUSE_FRAME) |=>
      !irq_stat_r[IB_PAUSE_FRAME])
    else $error("status not cleared by read");
  a_irq_read_keeps: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (irq_rd && irq_stat_r[IB_PAUSE_ZERO] && !O_PRDATA[IB_PAUSE_ZERO]) |=>
      irq_stat_r[IB_PAUSE_ZERO])
    else $error("unreported flag lost on status read");
  a_used_flag_rx: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_RX_USED_SEEN |=> irq_stat_r[IB_RX_USED])
    else $error("receive used flag interrupt lost");
  a_underrun_on_ptr: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    ptr_wr |=> irq_stat_r[IB_TX_UNDERRUN])
    else $error("underrun not raised on pointer write");
  a_retry_limit: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_RETRY_LIMIT |=> irq_stat_r[IB_RETRY_LIMIT])
    else $error("retry limit interrupt lost");
  a_tx_complete: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_TX_FRAME_DONE |=> irq_stat_r[IB_TX_COMPLETE])
    else $error("transmit complete interrupt lost");
  a_ovr_pair: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_RX_STORE_FAIL |=> irq_stat_r[IB_RX_OVERRUN] &&
      rx_stat_r[RS_OVERRUN])
    else $error("overrun flags not raised together");
  a_bus_error: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_BUS_ERROR |=> irq_stat_r[IB_BUS_ERROR] && irq_stat_r[IB_TX_UNDERRUN])
    else $error("bus error interrupts lost");
  a_mask_enable: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (wr && I_PADDR == OFF_IRQ_EN_SET && I_PWDATA[IB_TX_COMPLETE]) |=>
      !mask_r[IB_TX_COMPLETE])
    else $error("enable did not unmask");
  a_mask_disable: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (wr && I_PADDR == OFF_IRQ_EN_CLR && I_PWDATA[IB_BUS_ERROR]) |=>
      mask_r[IB_BUS_ERROR])
    else $error("disable did not mask");
  a_mask_readback: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (setup && I_PADDR == OFF_IRQ_MASK) |=>
      O_PRDATA == {{(32-IRQ_W){1'b0}}, $past(mask_r)})
    else $error("mask view does not match mask");
  a_tx_status_read: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (setup && I_PADDR == OFF_TX_STATUS) |=>
      O_PRDATA[TS_ACTIVE] == $past(I_TX_ACTIVE))
    else $error("transmit active bit misread");
  a_irq_output: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    ##1 O_IRQ == |(irq_stat_r & ~mask_r))
    else $error("interrupt output mismatch");
  a_irq_event_fires: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_MGMT_DONE && !mask_r[IB_MGMT_DONE] &&
     !(wr && I_PADDR == OFF_IRQ_EN_CLR)) |=> O_IRQ)
    else $error("unmasked event did not raise interrupt");

  c_ptr_load: cover property (@(posedge I_SYS_CLK) disable iff (I_RST)
    ptr_wr ##1 I_TX_BUF_DONE);
  c_ptr_blocked: cover property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && I_PADDR == OFF_TXQ_PTR && I_TX_ACTIVE);
  c_irq_fire: cover property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !O_IRQ ##1 O_IRQ);
  c_read_clear: cover property (@(posedge I_SYS_CLK) disable iff (I_RST)
    irq_rd && |irq_stat_r);
  c_rx_clear: cover property (@(posedge I_SYS_CLK) disable iff (I_RST)
    rx_stat_r[RS_FRAME_RCVD] ##1 !rx_stat_r[RS_FRAME_RCVD]);
endmodule : mdsi_top

// *** mdsi_partner.sv ***
// Partner model: DMA and transmitter event source beside the status block
`timescale 1ns/1ps
module mdsi_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_fire,
  input wire logic i_busy,
  output logic [15:0] o_ev,
  output logic o_tx_active
);
  logic [15:0] ev_nxt;
  logic act_nxt;
  ////////////////////////////////////////////////////////////////////////////
  // Events follow i_fire one cycle later and last as long as it is held
  always_comb begin
    ev_nxt = i_fire;
    act_nxt = i_busy;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ev <= 16'h0000;
      o_tx_active <= 1'b0;
    end else begin
      o_ev <= ev_nxt;
      o_tx_active <= act_nxt;
    end
  end
endmodule : mdsi_partner

// *** test_mac_dma_status_and_interrupts.sv ***
// Testbench: APB host and event scenarios for the DMA status block
`timescale 1ns/1ps
module test_mac_dma_status_and_interrupts;
  import mdsi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ptr_load, irq, tx_act, busy = 1'b0;
  logic [15:0] fire_v = 16'h0000;
  logic [15:0] ev;
  logic [31:0] txq_ptr;
  logic [32:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int loads = 0;
  int seed = 32'h00da;
  logic [31:0] r;
  // Expected irq and rx status per event line of the partner
  logic [31:0] irq_exp [14] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20,
    32'h40, 32'h80, 32'h400, 32'h810, 32'h1000, 32'h2000, 32'h10, 32'h0};
  logic [31:0] rs_exp [14] = '{0, 2, 0, 0, 0, 0, 0, 0, 4, 0, 0, 0, 0, 1};
  localparam logic [31:0] BASE = 32'h4000_0000;
  always #12.5 clk = ~clk;
  mdsi_partner part_u (.i_clk(clk), .i_rst(rst), .i_fire(fire_v),
    .i_busy(busy), .o_ev(ev), .o_tx_active(tx_act));
  mdsi_top dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_TX_ACTIVE(tx_act), .I_TX_BUF_DONE(ev[14]),
    .I_TX_WRAP_SEEN(ev[15]), .I_TX_FRAME_DONE(ev[7]),
    .I_RX_DESC_OWNED(ev[13]), .I_RX_FRAME_STORED(ev[1]),
    .I_RX_STORE_FAIL(ev[8]), .I_RX_USED_SEEN(ev[2]),
    .I_TX_USED_SEEN(ev[3]), .I_TX_LATE_DATA(ev[4]),
    .I_TX_USED_MIDFRAME(ev[12]), .I_BUS_ERROR(ev[9]),
    .I_MGMT_DONE(ev[0]), .I_RETRY_LIMIT(ev[5]), .I_TX_EXHAUST(ev[6]),
    .I_PAUSE_FRAME(ev[10]), .I_PAUSE_ZERO(ev[11]), .O_TXQ_PTR(txq_ptr),
    .O_PTR_LOAD(ptr_load), .O_IRQ(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors=%0d checked=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Called just after a rising edge; ends one edge after release
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers ends the run as a failure
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {1'b0, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask : wr
  task automatic fire(input logic [15:0] v);
    fire_v <= v;
    @(posedge clk);
    fire_v <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask : fire
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: read data and error taken at the completing edge
  always @(posedge clk) begin
    if (ptr_load === 1'b1) loads++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk(33'h1_dead_beef, 33'h0);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    #(25ns * 20000);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFF_TXQ_PTR, PTR_RST);
    rd(OFF_IRQ_MASK, {18'h0, MASK_RST});
    // Unmapped addresses read zero with an error response
    apb(1'b0, 8'h3c, 32'h0, 33'h1_0000_0000);
    apb(1'b0, 8'h00, 32'h0, 33'h1_0000_0000);
    wr(OFF_TXQ_PTR, BASE);
    rd(OFF_TXQ_PTR, BASE);
    chk(33'(loads), 33'h1);
    rd(OFF_IRQ_STATUS, 32'h10);
    repeat (1023) fire(16'h4000);
    fire(16'h0080);
    rd(OFF_TXQ_PTR, BASE + 32'h1ff8);
    chk({1'b0, txq_ptr}, {1'b0, BASE + 32'h1ff8});
    fire(16'h4000);
    fire(16'h0080);
    rd(OFF_TXQ_PTR, BASE);
    repeat (2) fire(16'h4000);
    fire(16'h0080);
    rd(OFF_TXQ_PTR, BASE + 32'h10);
    fire(16'hc000);
    fire(16'h0080);
    rd(OFF_TXQ_PTR, BASE);
    rd(OFF_IRQ_STATUS, 32'h80);
    busy <= 1'b1;
    repeat (2) @(posedge clk);
    wr(OFF_TXQ_PTR, 32'h5000_0000);
    rd(OFF_TXQ_PTR, BASE);
    chk(33'(loads), 33'h1);
    rd(OFF_TX_STATUS, 32'h8);
    rd(OFF_IRQ_STATUS, 32'h0);
    busy <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFF_TX_STATUS, 32'h0);
    wr(OFF_IRQ_EN_SET, {18'h0, MASK_RST});
    rd(OFF_IRQ_MASK, 32'h300);
    for (int e = 0; e < 14; e++) begin
      fire(16'h1 << e);
      chk({32'h0, irq}, {32'h0, irq_exp[e] != 0});
      rd(OFF_IRQ_STATUS, irq_exp[e]);
      rd(OFF_IRQ_STATUS, 32'h0);
      chk({32'h0, irq}, 33'h0);
      rd(OFF_RX_STATUS, rs_exp[e]);
      wr(OFF_RX_STATUS, ~rs_exp[e]);
      rd(OFF_RX_STATUS, rs_exp[e]);
      wr(OFF_RX_STATUS, rs_exp[e]);
      rd(OFF_RX_STATUS, 32'h0);
    end
    // Event landing in the setup cycle of a status read stays pending
    fork
      fire(16'h0800);
      begin
        @(posedge clk);
        rd(OFF_IRQ_STATUS, 32'h0);
      end
    join
    rd(OFF_IRQ_STATUS, 32'h2000);
    fire(16'h2000);
    fire(16'h2000);
    rd(OFF_RX_STATUS, 32'h1);
    wr(OFF_RX_STATUS, 32'h1);
    wr(OFF_IRQ_EN_CLR, {18'h0, MASK_RST});
    rd(OFF_IRQ_MASK, {18'h0, MASK_RST});
    r = $random(seed) & {18'h0, IRQ_IMPL};
    wr(OFF_IRQ_EN_SET, r);
    wr(OFF_IRQ_EN_SET, 32'h0);
    wr(OFF_IRQ_EN_CLR, 32'h0);
    rd(OFF_IRQ_MASK, {18'h0, MASK_RST} & ~r);
    fire(16'h0001);
    chk({32'h0, irq}, {32'h0, r[0]});
    rd(OFF_IRQ_STATUS, 32'h1);
    complete_run();
  end
endmodule : test_mac_dma_status_and_interrupts
